// ===== rtl/mc_flop.sv
`timescale 1ns/100ps
module mc_flop
    import macrocell_pkg::*;
(
    // system
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // control
    input wire cell_kind_t i_kind,
    input wire logic i_edge,
    input wire logic i_a,
    input wire logic i_b,
    input wire logic i_clear,
    // state
    output logic o_q
);
    function automatic logic next_state(cell_kind_t k, logic a, logic b, logic q);
        case (k)
            KIND_T: return a ? ~q : q;
            KIND_JK: begin
                case ({a, b})
                    2'b10: return 1'b1;
                    2'b01: return 1'b0;
                    2'b11: return ~q;
                    default: return q;
                endcase
            end
            KIND_SR: begin
                case ({a, b})
                    2'b10: return 1'b1;
                    2'b01: return 1'b0;
                    default: return q;
                endcase
            end
            default: return a;
        endcase
    endfunction

    logic q_r;
    wire q_nxt = next_state(i_kind, i_a, i_b, q_r);

    // clear wins over any edge in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            q_r <= 1'b0;
        end else if (i_clear) begin
            q_r <= 1'b0;
        end else if (i_edge) begin
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;
endmodule

// ===== rtl/mc_power.sv
`timescale 1ns/100ps
module mc_power
    import macrocell_pkg::*;
#(
    parameter int DEPTH = ADDER_CYC,
    parameter int IDLE_CYC = STANDBY_CYC,
    parameter int ACT_W = 4
)(
    // system
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // mode and activity
    input wire logic i_fast,
    input wire logic [ACT_W-1:0] i_activity,
    input wire pin_drive_t i_drive,
    // outputs
    output pin_drive_t o_drive,
    output logic o_standby
);
    localparam int CW = $clog2(IDLE_CYC + 1);
    localparam logic [CW-1:0] IDLE_MAX = CW'(IDLE_CYC);

    if (DEPTH < 1 || IDLE_CYC < 1 || ACT_W < 1) begin : g_bad
        $error("mc_power: depth, idle count and activity width must be at least one");
    end

    logic [ACT_W-1:0] act_prev_r;
    logic [CW-1:0] idle_r;
    pin_drive_t pipe_r [DEPTH];
    pin_drive_t out_r;

    wire changed = (i_activity != act_prev_r);
    wire [CW-1:0] idle_nxt = changed ? '0 : ((idle_r == IDLE_MAX) ? idle_r : idle_r + CW'(1));

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            act_prev_r <= '0;
            idle_r <= '0;
            out_r <= '0;
        end else begin
            act_prev_r <= i_activity;
            idle_r <= idle_nxt;
            // low-power path carries the extra adder delay
            out_r <= i_fast ? i_drive : pipe_r[DEPTH-1];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            pipe_r[0] <= i_drive;
            for (int i = 1; i < DEPTH; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    assign o_drive = out_r;
    assign o_standby = !i_fast && (idle_r == IDLE_MAX);
endmodule

// ===== rtl/programmable_macrocell.sv
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module programmable_macrocell
    import macrocell_pkg::*;
#(
    parameter int CELL_INDEX = 1
)(
    // system
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // register bus
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // product terms from the array, same clock
    input wire logic [NUM_TERMS-1:0] i_pt_sum,
    input wire logic i_pt_oe_clk,
    input wire logic i_pt_clear,
    // global clock pins
    input wire logic i_global_clock_upper_cells,
    input wire logic i_global_clock_lower_cells,
    // io pin
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe,
    // feedback into the array
    output logic o_fb,
    output logic o_fb_en,
    // power state
    output logic o_standby
);
    if (CELL_INDEX < FIRST_CELL || CELL_INDEX > LAST_CELL) begin : g_bad
        $error("programmable_macrocell: cell index out of range");
    end

    localparam bit USE_UPPER = (CELL_INDEX >= UPPER_FIRST_CELL);
    localparam int ACT_W = NUM_TERMS + 4;

    // ---------------- register bus slave ----------------
    logic ack_r;
    logic [31:0] rdata_r;
    cfg_t cfg_r;
    cfg_t cfg_nxt;
    ctrl_t ctrl_r;
    ctrl_t ctrl_nxt;

    wire req = i_avs_read | i_avs_write;
    wire wr_take = i_avs_write & ack_r;
    wire rd_load = i_avs_read & ~ack_r;
    wire sel_cfg = (i_avs_address == OFS_CFG);
    wire sel_ctrl = (i_avs_address == OFS_CTRL);
    wire sel_erase = (i_avs_address == OFS_ERASE);
    wire sel_status = (i_avs_address == OFS_STATUS);
    wire erase_take = wr_take & sel_erase;

    // one wait state on every access, mapped or not
    assign o_avs_waitrequest = req & ~ack_r;
    assign o_avs_readdata = rdata_r;

    always_comb begin
        cfg_nxt = cfg_r;
        ctrl_nxt = ctrl_r;
        if (erase_take) begin
            cfg_nxt = CFG_RESET;
            ctrl_nxt = CTRL_RESET;
        end else if (wr_take) begin
            if (sel_cfg && i_avs_byteenable[0]) begin
                cfg_nxt[7:0] = i_avs_writedata[7:0];
            end
            if (sel_cfg && i_avs_byteenable[1]) begin
                cfg_nxt[15:8] = i_avs_writedata[15:8];
            end
            if (sel_ctrl && i_avs_byteenable[0]) begin
                ctrl_nxt = ctrl_t'(i_avs_writedata[1:0]);
            end
        end
    end

    // ---------------- pin and clock synchronisers ----------------
    logic pin_s1_r;
    logic pin_s2_r;
    logic gclk_s1_r;
    logic gclk_s2_r;
    logic gclk_s3_r;
    logic pt_clk_prev_r;

    wire gclk_pin = USE_UPPER ? i_global_clock_upper_cells : i_global_clock_lower_cells;
    wire gclk_rise = gclk_s2_r & ~gclk_s3_r;
    wire array_rise = i_pt_oe_clk & ~pt_clk_prev_r;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            gclk_s1_r <= 1'b0;
            gclk_s2_r <= 1'b0;
            gclk_s3_r <= 1'b0;
            pt_clk_prev_r <= 1'b0;
        end else begin
            pin_s1_r <= i_pin;
            pin_s2_r <= pin_s1_r;
            gclk_s1_r <= gclk_pin;
            gclk_s2_r <= gclk_s1_r;
            gclk_s3_r <= gclk_s2_r;
            pt_clk_prev_r <= i_pt_oe_clk;
        end
    end

    // ---------------- configuration decode ----------------
    // undefined kind codes fall back to combinational
    wire cell_kind_t kind_eff = (cfg_r.kind > KIND_SR) ? KIND_COMB : cfg_r.kind;
    wire registered = (kind_eff != KIND_COMB);
    wire two_input = (kind_eff == KIND_JK) || (kind_eff == KIND_SR);
    // feedback choices not offered by a configuration read as none
    wire fb_sel_t fb_eff = (cfg_r.fb == FB_REG && registered) ? FB_REG :
                           (cfg_r.fb == FB_PIN && !two_input) ? FB_PIN : FB_NONE;

    // ---------------- cell datapath ----------------
    logic q;
    wire sum_all = |i_pt_sum;
    wire sum_set = |(i_pt_sum & cfg_r.split);
    wire sum_reset = |(i_pt_sum & ~cfg_r.split);
    wire flop_a = two_input ? sum_set : sum_all;
    wire clk_edge = cfg_r.clk_mode ? array_rise : gclk_rise;
    wire q_vis = q & ~i_pt_clear;
    wire core_val = registered ? q_vis : sum_all;
    wire pin_drive_t drive;

    assign drive.val = core_val ^ cfg_r.invert;
    // mode 1 only frees the buffer for registered cells; combinational uses the term
    assign drive.oe = cfg_r.out_off ? 1'b0 :
                      (registered && cfg_r.clk_mode) ? 1'b1 : i_pt_oe_clk;

    mc_flop u_flop (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_kind(kind_eff),
        .i_edge(clk_edge & registered),
        .i_a(flop_a),
        .i_b(sum_reset),
        .i_clear(i_pt_clear),
        .o_q(q)
    );

    pin_drive_t pin_r;

    mc_power #(
        .DEPTH(ADDER_CYC),
        .IDLE_CYC(STANDBY_CYC),
        .ACT_W(ACT_W)
    ) u_power (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_fast(ctrl_r.fast),
        .i_activity({i_pt_sum, i_pt_oe_clk, i_pt_clear, pin_s2_r, gclk_s2_r}),
        .i_drive(drive),
        .o_drive(pin_r),
        .o_standby(o_standby)
    );

    assign o_pin = pin_r.val;
    assign o_pin_oe = pin_r.oe;

    // ---------------- feedback and register file ----------------
    logic fb_r;
    logic fb_en_r;
    wire fb_val = (fb_eff == FB_REG) ? q_vis : pin_s2_r;

    wire [31:0] status_word = {28'h0000000, o_standby, pin_r.oe, pin_s2_r, q_vis};
    // a locked cell reads its configuration as zero
    wire [31:0] rd_mux = sel_cfg ? (ctrl_r.lock ? 32'h00000000 : {16'h0000, cfg_r}) :
                         sel_ctrl ? {30'h00000000, ctrl_r} :
                         sel_status ? status_word : 32'h00000000;

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
            cfg_r <= CFG_RESET;
            ctrl_r <= CTRL_RESET;
            fb_r <= 1'b0;
            fb_en_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
            if (rd_load) begin
                rdata_r <= rd_mux;
            end
            cfg_r <= cfg_nxt;
            ctrl_r <= ctrl_nxt;
            fb_r <= (fb_eff == FB_NONE) ? 1'b0 : fb_val;
            fb_en_r <= (fb_eff != FB_NONE);
        end
    end

    assign o_fb = fb_r;
    assign o_fb_en = fb_en_r;

    // ---------------- assertions ----------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    sequence s_edge(cell_kind_t k);
        clk_edge && (kind_eff == k) && !i_pt_clear;
    endsequence

    sequence s_locked_cfg_read;
        i_avs_read && !o_avs_waitrequest && sel_cfg && ctrl_r.lock;
    endsequence

    a_comb_or_terms: assert property ((kind_eff == KIND_COMB && !cfg_r.out_off) |->
        (drive.oe == i_pt_oe_clk) && (drive.val == (sum_all ^ cfg_r.invert)))
        else $error("combinational output not the OR of the terms");
    a_d_load: assert property (s_edge(KIND_D) |=> q == $past(sum_all))
        else $error("d register did not load its input");
    a_t_toggle: assert property (s_edge(KIND_T) ##0 sum_all |=> q != $past(q))
        else $error("t register did not invert");
    a_t_hold: assert property (s_edge(KIND_T) ##0 !sum_all |=> $stable(q))
        else $error("t register did not hold");
    a_jk_toggle: assert property (s_edge(KIND_JK) ##0 (sum_set && sum_reset) |=> q == !$past(q))
        else $error("jk register did not toggle");
    a_sr_both_hold: assert property (s_edge(KIND_SR) ##0 (sum_set && sum_reset) |=> $stable(q))
        else $error("sr register changed on unsupported input");
    a_clear_low: assert property (i_pt_clear |-> !q_vis ##1 !q)
        else $error("clear did not force the register low");
    a_mode1_oe: assert property ((registered && cfg_r.clk_mode && !cfg_r.out_off) |-> drive.oe)
        else $error("mode 1 output not enabled");
    a_mode0_clock: assert property ((registered && !cfg_r.clk_mode && !i_pt_clear && !gclk_rise) |=>
        $stable(q))
        else $error("mode 0 register moved without a global clock edge");
    a_jk_no_pin: assert property (two_input |-> fb_eff != FB_PIN)
        else $error("pin feedback offered to a two-input register");
    a_lock_hides: assert property (s_locked_cfg_read |-> o_avs_readdata == 32'h00000000)
        else $error("locked configuration was readable");
    a_erase_defaults: assert property (erase_take |=> (cfg_r == CFG_RESET) && !ctrl_r.lock)
        else $error("erase did not restore the unprogrammed state");
    // the delay pipe only holds real history three cycles after reset
    a_slow_adder: assert property (($past(i_resetn) && $past(i_resetn, 2) && $past(i_resetn, 3) &&
        $past(!ctrl_r.fast)) |-> o_pin == $past(drive.val, 3))
        else $error("low-power path delay wrong");
    a_fast_path: assert property ($past(ctrl_r.fast) |-> (o_pin == $past(drive.val)) && !$past(o_standby))
        else $error("fast mode path delay or standby wrong");
    a_dedicated_in: assert property ((cfg_r.out_off && fb_eff == FB_PIN) |->
        !drive.oe ##1 o_fb == $past(pin_s2_r))
        else $error("pin not a dedicated input");
endmodule

// ===== shared/macrocell_pkg.sv
package macrocell_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDER_NS = 20;
    localparam int ADDER_CYC = (ADDER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STANDBY_NS = 100;
    localparam int STANDBY_CYC = STANDBY_NS / CLK_PERIOD_NS;
    localparam int NUM_TERMS = 8;
    localparam int FIRST_CELL = 1;
    localparam int UPPER_FIRST_CELL = 9;
    localparam int LAST_CELL = 16;

    localparam logic [3:0] OFS_CFG = 4'h0;
    localparam logic [3:0] OFS_CTRL = 4'h4;
    localparam logic [3:0] OFS_ERASE = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    localparam int STAT_Q_BIT = 0;
    localparam int STAT_PIN_BIT = 1;
    localparam int STAT_OE_BIT = 2;
    localparam int STAT_STANDBY_BIT = 3;

    typedef enum logic [2:0] {
        KIND_COMB = 3'h0,
        KIND_D = 3'h1,
        KIND_T = 3'h2,
        KIND_JK = 3'h3,
        KIND_SR = 3'h4
    } cell_kind_t;

    typedef enum logic [1:0] {
        FB_NONE = 2'h0,
        FB_PIN = 2'h1,
        FB_REG = 2'h2
    } fb_sel_t;

    // bits 15:8 split, 7 clk_mode, 6 out_off, 5:4 fb, 3 invert, 2:0 kind
    typedef struct packed {
        logic [7:0] split;
        logic clk_mode;
        logic out_off;
        fb_sel_t fb;
        logic invert;
        cell_kind_t kind;
    } cfg_t;

    typedef struct packed {
        logic fast;
        logic lock;
    } ctrl_t;

    typedef struct packed {
        logic oe;
        logic val;
    } pin_drive_t;

    localparam cfg_t CFG_RESET = '{split: 8'hF0, clk_mode: 1'b0, out_off: 1'b0,
                                   fb: FB_PIN, invert: 1'b1, kind: KIND_COMB};
    localparam ctrl_t CTRL_RESET = '{fast: 1'b0, lock: 1'b0};
endpackage

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import macrocell_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] i_avs_address = 4'h0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [7:0] i_pt_sum = 8'h00;
    logic i_pt_oe_clk = 1'b0;
    logic i_pt_clear = 1'b0;
    logic i_global_clock_upper_cells = 1'b0;
    logic i_global_clock_lower_cells = 1'b0;
    logic i_pin = 1'b0;
    logic o_pin;
    logic o_pin_oe;
    logic o_fb;
    logic o_fb_en;
    logic o_standby;
    logic [31:0] rdat;
    int num_errors = 0;
    int checks = 0;
    // walk of j/k codes, two bits per step, lowest step first
    localparam logic [15:0] SEQ = 16'hE7C8;

    always #5 i_clk_sys = ~i_clk_sys;

    programmable_macrocell #(.CELL_INDEX(1)) DUT (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_pt_sum(i_pt_sum), .i_pt_oe_clk(i_pt_oe_clk), .i_pt_clear(i_pt_clear),
        .i_global_clock_upper_cells(i_global_clock_upper_cells),
        .i_global_clock_lower_cells(i_global_clock_lower_cells),
        .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
        .o_fb(o_fb), .o_fb_en(o_fb_en), .o_standby(o_standby)
    );

    task automatic end_sim;
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // the request stands until waitrequest is seen low at a rising edge; data is taken at that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        @(posedge i_clk_sys);
        i_avs_address <= a;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        i_avs_writedata <= wd;
        i_avs_byteenable <= be;
        n = 0;
        @(posedge i_clk_sys);
        while (o_avs_waitrequest) begin
            n++;
            if (n > 20) begin
                num_errors++;
                end_sim();
            end
            @(posedge i_clk_sys);
        end
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, 4'hF, x);
    endtask

    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'hF, rdat);
    endtask

    function automatic logic [31:0] cfgw(cell_kind_t k, logic inv, fb_sel_t fb, logic off, logic md);
        cfg_t c;
        c = '{split: 8'h0F, clk_mode: md, out_off: off, fb: fb, invert: inv, kind: k};
        return {16'h0000, c};
    endfunction

    task automatic drive(input logic [7:0] s, input logic oe, input logic pin);
        @(posedge i_clk_sys);
        i_pt_sum <= s;
        i_pt_oe_clk <= oe;
        i_pin <= pin;
    endtask

    // outputs pass synchronisers and the power delay, so give them time to settle
    task automatic settle;
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask

    task automatic pulse(input int src);
        @(posedge i_clk_sys);
        if (src == 0) i_global_clock_lower_cells <= 1'b1;
        else if (src == 1) i_global_clock_upper_cells <= 1'b1;
        else i_pt_oe_clk <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        i_global_clock_lower_cells <= 1'b0;
        i_global_clock_upper_cells <= 1'b0;
        i_pt_oe_clk <= (src == 2) ? 1'b0 : i_pt_oe_clk;
        repeat (5) @(posedge i_clk_sys);
    endtask

    task automatic set_clear(input logic v);
        @(posedge i_clk_sys);
        i_pt_clear <= v;
    endtask

    task automatic chk_q(input logic e);
        rd(OFS_STATUS);
        check(rdat[STAT_Q_BIT], e);
    endtask

    task automatic t_regs;
        rd(OFS_CFG);
        check(rdat, {16'h0000, 8'hF0, 8'h18});
        rd(OFS_CTRL);
        check(rdat, 32'h0);
        rd(4'h1);
        check(rdat, 32'h0);
        bus(1'b1, OFS_CFG, 32'h0000_0012, 4'h2, rdat);
        rd(OFS_CFG);
        check(rdat, 32'h0000_0018);
        wr(OFS_ERASE, 32'h0);
        drive(8'h01, 1'b1, 1'b1);
        settle();
        check({o_pin, o_pin_oe, o_fb, o_fb_en}, 4'b0111);
    endtask

    task automatic t_comb;
        wr(OFS_CTRL, 32'h2);
        wr(OFS_CFG, cfgw(KIND_COMB, 1'b0, FB_PIN, 1'b0, 1'b0));
        for (int i = 0; i < 8; i++) begin
            drive(8'h01 << i, 1'b1, 1'b0);
            settle();
            check({o_pin, o_pin_oe, o_fb}, 3'b110);
        end
        drive(8'h00, 1'b1, 1'b1);
        settle();
        check({o_pin, o_pin_oe, o_fb, o_fb_en}, 4'b0111);
        drive(8'h80, 1'b0, 1'b1);
        settle();
        check(o_pin_oe, 1'b0);
        wr(OFS_CFG, cfgw(KIND_COMB, 1'b1, FB_NONE, 1'b0, 1'b0));
        drive(8'h10, 1'b1, 1'b1);
        settle();
        check({o_pin, o_pin_oe, o_fb, o_fb_en}, 4'b0100);
    endtask

    task automatic t_walk(input cell_kind_t k);
        logic q;
        logic j;
        logic kk;
        wr(OFS_CFG, cfgw(k, 1'b0, FB_REG, 1'b0, 1'b0));
        set_clear(1'b1);
        set_clear(1'b0);
        q = 1'b0;
        for (int i = 0; i < 8; i++) begin
            j = SEQ[2*i+1];
            kk = SEQ[2*i];
            drive({3'b000, kk, 3'b000, j}, 1'b1, 1'b0);
            pulse(0);
            case (k)
                KIND_D: q = j | kk;
                KIND_T: q = (j | kk) ? ~q : q;
                KIND_JK: q = (j & kk) ? ~q : j ? 1'b1 : kk ? 1'b0 : q;
                default: q = (j & kk) ? q : j ? 1'b1 : kk ? 1'b0 : q;
            endcase
            chk_q(q);
            settle();
            check({o_pin, o_pin_oe, o_fb, o_fb_en}, {q, 1'b1, q, 1'b1});
        end
    endtask

    task automatic t_clock;
        wr(OFS_CFG, cfgw(KIND_D, 1'b1, FB_REG, 1'b0, 1'b0));
        set_clear(1'b1);
        set_clear(1'b0);
        drive(8'h04, 1'b1, 1'b0);
        pulse(1);
        chk_q(1'b0);
        pulse(0);
        chk_q(1'b1);
        settle();
        check(o_pin, 1'b0);
        set_clear(1'b1);
        chk_q(1'b0);
        pulse(0);
        chk_q(1'b0);
        set_clear(1'b0);
        wr(OFS_CFG, cfgw(KIND_D, 1'b0, FB_REG, 1'b0, 1'b1));
        drive(8'h04, 1'b0, 1'b0);
        settle();
        check(o_pin_oe, 1'b1);
        pulse(0);
        chk_q(1'b0);
        pulse(2);
        chk_q(1'b1);
    endtask

    task automatic t_feedback;
        wr(OFS_CFG, cfgw(KIND_T, 1'b0, FB_REG, 1'b1, 1'b0));
        drive(8'h00, 1'b1, 1'b0);
        settle();
        check({o_pin_oe, o_fb, o_fb_en}, 3'b011);
        wr(OFS_CFG, cfgw(KIND_JK, 1'b0, FB_PIN, 1'b0, 1'b0));
        drive(8'h00, 1'b1, 1'b1);
        settle();
        check(o_fb_en, 1'b0);
        wr(OFS_CFG, cfgw(KIND_COMB, 1'b0, FB_PIN, 1'b1, 1'b0));
        drive(8'hFF, 1'b1, 1'b1);
        settle();
        check({o_pin_oe, o_fb, o_fb_en}, 3'b011);
        drive(8'hFF, 1'b1, 1'b0);
        settle();
        check({o_pin_oe, o_fb}, 2'b00);
    endtask

    task automatic t_lock_power;
        wr(OFS_CTRL, 32'h3);
        rd(OFS_CFG);
        check(rdat, 32'h0);
        wr(OFS_ERASE, 32'h0);
        rd(OFS_CTRL);
        check(rdat, 32'h0);
        rd(OFS_CFG);
        check(rdat, {16'h0000, 8'hF0, 8'h18});
        repeat (30) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check(o_standby, 1'b1);
        wr(OFS_CTRL, 32'h2);
        repeat (30) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check(o_standby, 1'b0);
    endtask

    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        t_regs();
        t_comb();
        t_walk(KIND_D);
        t_walk(KIND_T);
        t_walk(KIND_JK);
        t_walk(KIND_SR);
        t_clock();
        t_feedback();
        t_lock_power();
        end_sim();
    end
endmodule
